// File: pio_pkg.sv
// Shared constants, register map and configuration types of the parallel I/O port.
// Assumes a 32-bit APB register bus and one system clock.
package pio_pkg;

  // Widest port that the block can be generated with
  localparam int PIO_MAX_WIDTH = 32;
  // Register bus widths
  localparam int PIO_DW = 32;
  localparam int PIO_AW = 4;

  // Byte offsets of the four registers
  localparam logic [PIO_AW-1:0] PIO_OFF_DATA = 4'h0;
  localparam logic [PIO_AW-1:0] PIO_OFF_DIR = 4'h4;
  localparam logic [PIO_AW-1:0] PIO_OFF_MASK = 4'h8;
  localparam logic [PIO_AW-1:0] PIO_OFF_EDGE = 4'hC;
  // Word-alignment bits of the address
  localparam int PIO_ALIGN_BITS = 2;

  // Reset value of every software register
  localparam logic [PIO_DW-1:0] PIO_RST_VAL = 32'h0000_0000;
  // Value returned by an absent register
  localparam logic [PIO_DW-1:0] PIO_ABSENT_VAL = 32'h0000_0000;
  // All ports driven
  localparam logic [PIO_DW-1:0] PIO_ALL_ONES = 32'hFFFF_FFFF;

  // Port direction configuration
  typedef enum logic [1:0] {
    PIO_DIR_IN = 2'b00,
    PIO_DIR_OUT = 2'b01,
    PIO_DIR_BOTH = 2'b10,
    PIO_DIR_BIDIR = 2'b11
  } pio_dir_e;

  // Kind of edge recorded
  typedef enum logic [1:0] {
    PIO_EDGE_RISE = 2'b00,
    PIO_EDGE_FALL = 2'b01,
    PIO_EDGE_ANY = 2'b10
  } pio_edge_e;

  // Interrupt source
  typedef enum logic {
    PIO_IRQ_LEVEL = 1'b0,
    PIO_IRQ_EDGE = 1'b1
  } pio_irq_e;

endpackage

// File: pio_sync.sv
// Three-stage input synchroniser with a two-stage agreement filter per bit.
// Assumes asynchronous pin inputs and one clock enable that freezes all stages.
`timescale 1ns/1ps
module pio_sync
  import pio_pkg::*;
#(
  parameter int W = pio_pkg::PIO_MAX_WIDTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar gi;

  // One synchroniser per port bit
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic s1; // First stage, read only by the second
      logic s2; // Second stage
      logic s3; // Third stage
      logic val; // Filtered level
      logic next_val;

      // Filtered level moves only when stages two and three agree
      always_comb
      begin
        next_val = val;
        if (s2 == s3)
        begin
          next_val = s3;
        end
      end

      // Register the stages, frozen while the enable is low
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          val <= 1'b0;
        end
        else if (ce)
        begin
          s1 <= d[gi];
          s2 <= s1;
          s3 <= s2;
          val <= next_val;
        end
      end

      assign q[gi] = val;
    end
  endgenerate

endmodule

// File: pio_edge.sv
// Per-bit edge detector and sticky edge record.
// Assumes synchronised levels and write-one-to-clear pulses from the register bus.
`timescale 1ns/1ps
module pio_edge
  import pio_pkg::*;
#(
  parameter int W = pio_pkg::PIO_MAX_WIDTH,
  parameter pio_pkg::pio_edge_e KIND = pio_pkg::PIO_EDGE_RISE
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] cap
);

  genvar gi;

  // One detector and record bit per port
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic prev; // Level one cycle earlier
      logic hit; // Edge of the chosen kind seen this cycle
      logic rec; // Sticky record bit
      logic next_rec;

      // Edge kind is a generation constant, software cannot change it
      always_comb
      begin
        case (KIND)
          PIO_EDGE_RISE: hit = level[gi] & ~prev;
          PIO_EDGE_FALL: hit = ~level[gi] & prev;
          PIO_EDGE_ANY: hit = level[gi] ^ prev;
          default: hit = 1'b0;
        endcase
        // A new edge wins over a clear in the same cycle
        next_rec = hit | (rec & ~clr[gi]);
      end

      // Register previous level and record
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          prev <= 1'b0;
          rec <= 1'b0;
        end
        else if (ce)
        begin
          prev <= level[gi];
          rec <= next_rec;
        end
      end

      assign cap[gi] = rec;
    end
  endgenerate

endmodule

// File: pio_top.sv
// Parallel I/O port with an APB register slave, edge record and one interrupt line.
// Assumes one clock, pins that may be asynchronous, and a pad that resolves pin_out by pin_oe.
//
// Summary of operation
// - One to thirty-two ports, fixed at generation
// - Input, output, both, or bidirectional tristate ports
// - Four registers: data, direction, mask, edge record
// - Absent registers read zero, writes ignored
// - Data read returns sampled input levels
// - Data write sets driven output value
// - Data read never returns written output data
// - Direction register tristates single bidirectional pins
// - Detected edges set sticky edge record bits
// - Edge kind fixed at generation, not writable
// - Level mode: high input is interrupt condition
// - Edge mode: configured edge kind raises interrupts
// - Mask register enables each input's interrupt
// - Single slave port, simple single transfers only
// - One interrupt request output
// - Registers 32 bits, low port bits meaningful
// - Bidirectional bit set to input is undriven
// - Level interrupt while masked input high
// - Edge interrupt while masked record bit set
`timescale 1ns/1ps
module pio_top
#(
  parameter int P_WIDTH = pio_pkg::PIO_MAX_WIDTH,
  parameter pio_pkg::pio_dir_e P_DIR = pio_pkg::PIO_DIR_BIDIR,
  parameter bit P_CAPTURE = 1'b1,
  parameter pio_pkg::pio_edge_e P_EDGE = pio_pkg::PIO_EDGE_RISE,
  parameter bit P_IRQ = 1'b1,
  parameter pio_pkg::pio_irq_e P_IRQ_MODE = pio_pkg::PIO_IRQ_EDGE
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pio_pkg::PIO_AW-1:0] paddr,
  input wire logic [pio_pkg::PIO_DW-1:0] pwdata,
  output logic [pio_pkg::PIO_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [pio_pkg::PIO_MAX_WIDTH-1:0] pin_in,
  output logic [pio_pkg::PIO_MAX_WIDTH-1:0] pin_out,
  output logic [pio_pkg::PIO_MAX_WIDTH-1:0] pin_oe
);
  import pio_pkg::*;

  // Bits above the generated width are forced to zero everywhere
  function automatic logic [PIO_DW-1:0] width_mask();
    logic [PIO_DW-1:0] m;
    m = PIO_RST_VAL;
    for (int i = 0; i < PIO_DW; i++)
    begin
      m[i] = (i < P_WIDTH);
    end
    return m;
  endfunction

  localparam logic [PIO_DW-1:0] WMASK = width_mask();
  // Which registers exist in this configuration
  localparam bit HAS_IN = (P_DIR != PIO_DIR_OUT);
  localparam bit HAS_OUT = (P_DIR != PIO_DIR_IN);
  localparam bit HAS_DIR = (P_DIR == PIO_DIR_BIDIR);
  localparam bit HAS_EDGE = HAS_IN && P_CAPTURE;
  localparam bit HAS_MASK = HAS_IN && P_IRQ;

  // Software registers
  logic [PIO_DW-1:0] out_val; // Value driven on output ports
  logic [PIO_DW-1:0] dir; // One means drive the pin
  logic [PIO_DW-1:0] mask; // Interrupt enable per input
  logic [PIO_DW-1:0] next_out_val;
  logic [PIO_DW-1:0] next_dir;
  logic [PIO_DW-1:0] next_mask;
  logic [PIO_DW-1:0] next_pin_out;
  logic [PIO_DW-1:0] next_pin_oe;

  // Bus state
  logic [PIO_DW-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // Derived bus terms
  logic acc_first; // First access cycle, answer is prepared here
  logic acc_done; // Access completes at this edge
  logic wr_done; // Write takes effect at this edge
  logic [PIO_AW-1:0] reg_addr; // Address with alignment bits cleared
  logic addr_ok; // Address word-aligned, alignment bits zero
  logic [PIO_DW-1:0] rd_mux; // Read value chosen by address

  // Input side
  logic [PIO_DW-1:0] in_sync; // Synchronised pin levels
  logic [PIO_DW-1:0] in_view; // Levels as software sees them
  logic [PIO_DW-1:0] edge_cap; // Edge record from the detector
  logic [PIO_DW-1:0] edge_view; // Edge record as software sees it
  logic [PIO_DW-1:0] edge_clr; // Write-one-to-clear pulses
  logic [PIO_DW-1:0] irq_src; // Interrupt source before the mask

  // Pins are asynchronous to clk, so they pass the three-stage filter
  pio_sync #(
    .W(PIO_DW)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(pin_in),
    .q(in_sync)
  );

  // Edge detector works on the filtered levels
  pio_edge #(
    .W(PIO_DW),
    .KIND(P_EDGE)
  ) u_edge (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(in_view),
    .clr(edge_clr),
    .cap(edge_cap)
  );

  // Read and write paths of the data register stay apart
  assign in_view = HAS_IN ? (in_sync & WMASK) : PIO_RST_VAL;
  assign edge_view = HAS_EDGE ? (edge_cap & WMASK) : PIO_RST_VAL;

  // Decode of the APB phases; no bursts exist on this bus
  always_comb
  begin
    acc_first = psel & penable & ~pready;
    acc_done = psel & penable & pready;
    wr_done = acc_done & pwrite;
    reg_addr = paddr & ~PIO_AW'((1 << PIO_ALIGN_BITS) - 1);
    addr_ok = (paddr[PIO_ALIGN_BITS-1:0] == '0);
  end

  // Read multiplexer; absent registers return a fixed value
  always_comb
  begin
    case (reg_addr)
      PIO_OFF_DATA: rd_mux = in_view;
      PIO_OFF_DIR: rd_mux = HAS_DIR ? (dir & WMASK) : PIO_ABSENT_VAL;
      PIO_OFF_MASK: rd_mux = HAS_MASK ? (mask & WMASK) : PIO_ABSENT_VAL;
      PIO_OFF_EDGE: rd_mux = edge_view;
      default: rd_mux = PIO_ABSENT_VAL;
    endcase
  end

  // Bus answer: one wait cycle, data registered with pready
  always_comb
  begin
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (acc_first)
    begin
      next_pready = 1'b1;
      // A misaligned address is the only refused access
      next_pslverr = ~addr_ok;
      next_prdata = (pwrite || !addr_ok) ? PIO_ABSENT_VAL : rd_mux;
    end
  end

  // Register writes; a write to an absent register leaves nothing changed
  always_comb
  begin
    next_out_val = out_val;
    next_dir = dir;
    next_mask = mask;
    edge_clr = PIO_RST_VAL;
    if (wr_done && addr_ok)
    begin
      case (reg_addr)
        PIO_OFF_DATA:
        begin
          if (HAS_OUT)
          begin
            next_out_val = pwdata & WMASK;
          end
        end
        PIO_OFF_DIR:
        begin
          if (HAS_DIR)
          begin
            next_dir = pwdata & WMASK;
          end
        end
        PIO_OFF_MASK:
        begin
          if (HAS_MASK)
          begin
            next_mask = pwdata & WMASK;
          end
        end
        PIO_OFF_EDGE:
        begin
          if (HAS_EDGE)
          begin
            edge_clr = pwdata & WMASK;
          end
        end
        default:
        begin
          next_out_val = out_val;
        end
      endcase
    end
  end

  // Pin drivers; enables follow direction only in bidirectional mode
  always_comb
  begin
    next_pin_out = HAS_OUT ? next_out_val : PIO_RST_VAL;
    case (P_DIR)
      PIO_DIR_BIDIR: next_pin_oe = next_dir & WMASK;
      PIO_DIR_OUT: next_pin_oe = WMASK;
      PIO_DIR_BOTH: next_pin_oe = WMASK;
      default: next_pin_oe = PIO_RST_VAL;
    endcase
  end

  // Interrupt source chosen at generation, then masked per input
  always_comb
  begin
    if (P_IRQ_MODE == PIO_IRQ_LEVEL)
    begin
      irq_src = in_view;
    end
    else
    begin
      irq_src = edge_view;
    end
    next_irq = HAS_MASK && ((irq_src & mask & WMASK) != PIO_RST_VAL);
  end

  // Register stage; a low enable freezes every bit of state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_val <= PIO_RST_VAL;
      dir <= PIO_RST_VAL;
      mask <= PIO_RST_VAL;
      pin_out <= PIO_RST_VAL;
      pin_oe <= PIO_RST_VAL;
      prdata <= PIO_RST_VAL;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      out_val <= next_out_val;
      dir <= next_dir;
      mask <= next_mask;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // Checks on bus timing, pins and interrupt
  sequence s_rd_data;
    ce && acc_first && !pwrite && addr_ok && reg_addr == PIO_OFF_DATA;
  endsequence

  sequence s_wr_reg(logic [PIO_AW-1:0] a);
    ce && wr_done && addr_ok && reg_addr == a;
  endsequence

  AST_RD_DATA: assert property (@(posedge clk) disable iff (rst)
    s_rd_data |=> pready && prdata == $past(in_view))
    else $error("Data read did not return sampled inputs");

  AST_WR_OUT: assert property (@(posedge clk) disable iff (rst)
    s_wr_reg(PIO_OFF_DATA) |=> pin_out == (HAS_OUT ? ($past(pwdata) & WMASK) : PIO_RST_VAL))
    else $error("Data write did not reach output pins");

  AST_RD_INDEP: assert property (@(posedge clk) disable iff (rst)
    s_wr_reg(PIO_OFF_DATA) ##[2:3] s_rd_data |=> prdata == $past(in_view))
    else $error("Data read echoed written data");

  AST_DIR_OE: assert property (@(posedge clk) disable iff (rst)
    s_wr_reg(PIO_OFF_DIR) ##0 HAS_DIR |=> pin_oe == ($past(pwdata) & WMASK))
    else $error("Direction write did not set pin enables");

  AST_ABSENT_WR: assert property (@(posedge clk) disable iff (rst)
    s_wr_reg(PIO_OFF_MASK) ##0 !HAS_MASK |=> mask == PIO_RST_VAL)
    else $error("Write to absent mask register took effect");

  AST_CAP_STICKY: assert property (@(posedge clk) disable iff (rst)
    ce && edge_clr == PIO_RST_VAL |=> (edge_cap & $past(edge_cap)) == $past(edge_cap))
    else $error("Edge record bit lost without a clear");

  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (rst)
    ce && mask == PIO_RST_VAL && $stable(mask) |=> !irq)
    else $error("Interrupt raised with all inputs masked");

  AST_IRQ_SRC: assert property (@(posedge clk) disable iff (rst)
    ce && HAS_MASK && ((irq_src & mask & WMASK) != PIO_RST_VAL) |=> irq)
    else $error("Interrupt missing for masked active source");

  AST_ANSWER: assert property (@(posedge clk) disable iff (rst)
    ce && psel && !penable ##1 ce && psel && penable |=> pready ##1 !pready)
    else $error("Bus answer not given after one wait cycle");

  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(irq) && $stable(pready))
    else $error("State moved while clock enable low");

endmodule

// File: pio_host.sv
// Host-side APB master model that reaches the port registers.
// Assumes a slave that ends each access with pready; the bench watchdog ends a hang.
`timescale 1ns/1ps
module pio_host
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [pio_pkg::PIO_AW-1:0] paddr,
  output logic [pio_pkg::PIO_DW-1:0] pwdata,
  input wire logic [pio_pkg::PIO_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import pio_pkg::*;

  // Bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0000_0000;
  end

  // One single transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [PIO_AW-1:0] a, input logic [PIO_DW-1:0] d,
                      output logic [PIO_DW-1:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Access phase length comes from the slave, not assumed here
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show a changed value so stale data cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// File: tb_parallel_io_port.sv
// Self-checking bench of the parallel I/O port in bidirectional, rising-edge, edge-interrupt form.
// Assumes the host model drives APB and the bench resolves the pads from pin_oe.
`timescale 1ns/1ps
module tb_parallel_io_port;
  import pio_pkg::*;

  logic clk;
  logic rst;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [PIO_AW-1:0] paddr;
  logic [PIO_DW-1:0] pwdata;
  logic [PIO_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [PIO_MAX_WIDTH-1:0] pin_in;
  logic [PIO_MAX_WIDTH-1:0] pin_out;
  logic [PIO_MAX_WIDTH-1:0] pin_oe;
  // Level that outside logic puts on undriven pads
  logic [PIO_MAX_WIDTH-1:0] ext;
  logic [PIO_DW-1:0] rd;
  logic er;
  int err_count;
  int num_checks;
  // Rows: register, value written, value read back after settling
  logic [PIO_AW-1:0] row_a [4] = '{PIO_OFF_MASK, PIO_OFF_DIR, PIO_OFF_DATA, PIO_OFF_EDGE};
  logic [PIO_DW-1:0] row_w [4] = '{32'h0000_0003, 32'h0000_00FF, 32'h1234_5678, 32'hFFFF_FFFF};
  logic [PIO_DW-1:0] row_e [4] = '{32'h0000_0003, 32'h0000_00FF, 32'hA5A5_0078, 32'h0000_0000};

  // Pad resolution: own drive wins where enabled, else the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  pio_top i_pio_top (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  pio_host i_pio_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 10 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare one value, counting every comparison
  task automatic chk(input string name, input logic [PIO_DW-1:0] exp, input logic [PIO_DW-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [PIO_AW-1:0] a, input logic [PIO_DW-1:0] d);
    i_pio_host.xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rd_reg(input logic [PIO_AW-1:0] a);
    i_pio_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #2000000;
    err_count++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ext = 32'hA5A5_0000;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("pin_oe", 32'h0000_0000, pin_oe);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd_reg(PIO_OFF_DIR);
    chk("dir", 32'h0000_0000, rd);
    idle(8);
    // Outside level rose from the reset value, so those bits are recorded
    rd_reg(PIO_OFF_EDGE);
    chk("edge", 32'hA5A5_0000, rd);
    $display("Test reset done");
    // Ordinary write then read of each register
    for (int i = 0; i < 4; i++)
    begin
      wr(row_a[i], row_w[i]);
      idle(8);
      rd_reg(row_a[i]);
      chk("row", row_e[i], rd);
    end
    chk("pin_oe", 32'h0000_00FF, pin_oe);
    chk("pin_out", 32'h1234_5678, pin_out);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("Test rows done");
    // Own drive raises bit 0: recorded, masked interrupt follows
    wr(PIO_OFF_DATA, 32'h1234_5679);
    idle(8);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd_reg(PIO_OFF_EDGE);
    chk("edge", 32'h0000_0001, rd);
    wr(PIO_OFF_MASK, 32'h0000_0000);
    idle(2);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    wr(PIO_OFF_MASK, 32'h0000_0001);
    idle(2);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(PIO_OFF_EDGE, 32'h0000_0001);
    idle(2);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    // A falling edge is not of the configured kind
    wr(PIO_OFF_DATA, 32'h1234_5678);
    idle(8);
    rd_reg(PIO_OFF_EDGE);
    chk("edge", 32'h0000_0000, rd);
    $display("Test interrupt done");
    // Written data differs from the pads above the driven byte, and must not come back
    wr(PIO_OFF_DATA, 32'hFFFF_FF78);
    rd_reg(PIO_OFF_DATA);
    chk("data", 32'hA5A5_0078, rd);
    $display("Test independence done");
    // Misaligned write is refused and changes nothing
    i_pio_host.xfer(1'b1, 4'h5, 32'h0000_0000, rd, er);
    chk("pslverr", 32'h0000_0001, {31'h0, er});
    rd_reg(PIO_OFF_DIR);
    chk("dir", 32'h0000_00FF, rd);
    $display("Test refusal done");
    // Low enable freezes sampling; the pad edge only counts once the enable is back
    wr(PIO_OFF_MASK, 32'h0000_0100);
    @(posedge clk);
    ce <= 1'b0;
    ext <= 32'hA5A5_0100;
    idle(8);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    ce <= 1'b1;
    idle(8);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd_reg(PIO_OFF_EDGE);
    chk("edge", 32'h0000_0100, rd);
    $display("Test freeze done");
    // Second reset in mid-run clears drive and mask
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pin_oe", 32'h0000_0000, pin_oe);
    chk("pin_out", 32'h0000_0000, pin_out);
    rd_reg(PIO_OFF_MASK);
    chk("mask", 32'h0000_0000, rd);
    $display("Test second reset done");
    complete_run();
  end
endmodule
